// ===== csm_analog_model.sv
`timescale 1ns/1ns
`default_nettype none

module csm_analog_model #(
  parameter int unsigned OSC_HALF = 6
) (
  input  wire logic       clock,
  input  wire logic [1:0] osc_mode,
  input  wire logic       trim_bad,
  input  wire logic       cmp_emulate,
  input  wire logic [3:0] trim_addr,
  output var  logic       osc_sample,
  output var  logic [7:0] cmp_test_resp,
  output var  logic [7:0] trim_data
);
  logic [4:0] osc_cnt;
  logic [4:0] half;

  initial begin
    osc_cnt = 5'h00;
    osc_sample = 1'b0;
    cmp_test_resp = 8'h00;
  end

  ////////////////////////////////////////////////////////////
  // Slow mode doubles the half period, well past the loss limit
  assign half = (osc_mode == 2'h3) ? 5'(OSC_HALF * 2) : 5'(OSC_HALF);

  always @(posedge clock) begin
    osc_cnt <= (osc_cnt + 5'h01 >= half) ? 5'h00 : osc_cnt + 5'h01;
    if (osc_mode == 2'h1) begin
      osc_sample <= 1'b1;
    end else if (osc_mode == 2'h2) begin
      osc_sample <= 1'b0;
    end else if (osc_cnt + 5'h01 >= half) begin
      osc_sample <= ~osc_sample;
    end
  end

  // Comparators follow the emulated rail, never the live one
  always @(posedge clock) begin
    cmp_test_resp <= {8{cmp_emulate}};
  end

  // All-zero words give a zero CRC; a bad check word breaks it
  assign trim_data = (trim_addr == 4'hf && trim_bad) ? 8'h01 : 8'h00;
endmodule

`default_nettype wire

// ===== csm_clk_mon.sv
`timescale 1ns/1ns
`default_nettype none
`include "csm_params.svh"

module csm_clk_mon #(
  parameter int unsigned HALF_MAX = `CSM_LOSS_HALF_CYC
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic enable,
  input  wire logic emulate,
  input  wire logic osc_sample,
  output var  logic loss
);

  logic       osc_q;
  logic [7:0] gap;

  always_ff @(posedge clock) begin
    if (rst) begin
      osc_q <= 1'b0;
    end else begin
      osc_q <= osc_sample;
    end
  end

  // Emulation only hides edges from this counter; the oscillator itself
  // is never touched.
  always_ff @(posedge clock) begin
    if (rst) begin
      gap <= 8'h00;
    end else if (!enable) begin
      gap <= 8'h00;
    end else if ((osc_sample != osc_q) && !emulate) begin
      gap <= 8'h00;
    end else if (gap != 8'hff) begin
      gap <= gap + 8'h01;
    end
  end

  // Stuck high, stuck low and a slow clock all stretch the gap.
  always_ff @(posedge clock) begin
    if (rst) begin
      loss <= 1'b0;
    end else begin
      loss <= enable && (gap >= 8'(HALF_MAX));
    end
  end

endmodule
`default_nettype wire

// ===== csm_params.svh
`ifndef CSM_PARAMS_SVH
`define CSM_PARAMS_SVH

// Timing
`define CSM_CLK_PERIOD_NS  20
`define CSM_TEST_TIME_US   300
`define CSM_TEST_CYCLES    ((`CSM_TEST_TIME_US * 1000) / `CSM_CLK_PERIOD_NS)
`define CSM_LOSS_FREQ_KHZ  2640
`define CSM_LOSS_HALF_CYC  ((1000000 / (2 * `CSM_LOSS_FREQ_KHZ)) / `CSM_CLK_PERIOD_NS)
`define CSM_CMP_HALF_CYC   6'h10
`define CSM_EMU_HALF_CYC   6'h20
`define CSM_HALVES         4'h8

// Sizes
`define CSM_RAILS          8
`define CSM_TRIM_WORDS     16
`define CSM_TRIM_AW        4
`define CSM_CRC_POLY       8'h07

// Register offsets
`define CSM_REG_CTRL       4'h0
`define CSM_REG_TSTAT      4'h1
`define CSM_REG_SAFE4      4'h2
`define CSM_REG_SMSTAT     4'h3
`define CSM_REG_STATE      4'h4
`define CSM_REG_MUXSEL     4'h5
`define CSM_REG_SENSOR     4'h6

// Field positions
`define CSM_CTRL_START     0
`define CSM_CTRL_CLKCHK    1
`define CSM_CTRL_GO_ACTIVE 2
`define CSM_TSTAT_RUN      0
`define CSM_TSTAT_FAIL     1
`define CSM_SAFE4_CLKLOST  0
`define CSM_SENSOR_CANEN   0

// Reset values
`define CSM_MUXSEL_RST     8'h00
`define CSM_SENSOR_RST     8'h00

// Diagnostic mux positions: {group[2:0], index[4:0]}
`define CSM_MUX_CLK_LOST   8'h30
`define CSM_MUX_OT_CAN     8'h6c
`define CSM_MUX_OT_IO      8'h6d
`define CSM_MUX_OT_SENSOR  8'h6e
`define CSM_MUX_CAN_CL     8'h6f
`define CSM_MUX_TRIM_ERR   8'h89

`endif

// ===== csm_pkg.sv
package csm_pkg;

  typedef enum logic [2:0] {
    st_standby,
    st_reset,
    st_diag,
    st_active,
    st_safe
  } csm_state_t;

  typedef enum logic [2:0] {
    ph_idle,
    ph_cmp,
    ph_clk,
    ph_crc,
    ph_wait,
    ph_done
  } csm_phase_t;

endpackage

// ===== csm_top.sv
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "csm_params.svh"

module csm_top #(
  parameter int unsigned TEST_CYCLES = `CSM_TEST_CYCLES,
  parameter int unsigned RAILS       = `CSM_RAILS,
  parameter int unsigned TRIM_WORDS  = `CSM_TRIM_WORDS,
  parameter int unsigned TRIM_AW     = `CSM_TRIM_AW
) (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                power_on_reset_n,
  input  wire logic                wake_request,
  input  wire logic                osc_sample,
  input  wire logic [RAILS-1:0]    cmp_raw,
  input  wire logic [RAILS-1:0]    cmp_test_resp,
  input  wire logic [7:0]          trim_data,
  input  wire logic [7:0]          mon_trim,
  input  wire logic [2:0]          overtemp,
  input  wire logic                can_rail_current_limit,
  input  wire logic [3:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_write,
  input  wire logic                reg_read,
  output var  logic [7:0]          reg_rdata,
  output var  csm_pkg::csm_state_t dev_state,
  output var  logic                regulators_enable,
  output var  logic                mcu_reset_n,
  output var  logic                power_stage_enable_out,
  output var  logic                supervision_enable,
  output var  logic                clock_monitor_enable,
  output var  logic                cmp_emulate,
  output var  logic [TRIM_AW-1:0]  trim_addr,
  output var  logic [RAILS-1:0]    supply_flags,
  output var  logic                monitor_trim_fault,
  output var  logic                diag_out
);

  csm_pkg::csm_phase_t phase;
  logic        mon_loss;
  logic        real_loss;
  logic        clk_emulate;
  logic        only_clk;
  logic        fail_acc;
  logic        analog_test_fail;
  logic        clock_lost_flag;
  logic        can_rail_enable;
  logic [7:0]  mux_sel;
  logic [15:0] cnt;
  logic [5:0]  sub;
  logic [3:0]  halves;
  logic [7:0]  crc;
  logic [7:0]  trim_ref;
  logic        trim_ref_valid;
  logic        ctrl_wr;
  logic        start_auto;
  logic        start_sw;
  logic        check_sw;
  logic        starting;
  logic        test_done;
  logic        running;
  logic        mcu_may_test;

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic [7:0] crc8_step(input logic [7:0] c,
                                           input logic [7:0] d);
    logic [7:0] r;
    integer     i;
    r = c ^ d;
    for (i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ `CSM_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  function automatic logic mux_pick(input logic [7:0] sel);
    logic v;
    v = 1'b0;
    if (sel == `CSM_MUX_CLK_LOST) begin
      v = mon_loss;
    end else if (sel == `CSM_MUX_OT_CAN) begin
      v = overtemp[0];
    end else if (sel == `CSM_MUX_OT_IO) begin
      v = overtemp[1];
    end else if (sel == `CSM_MUX_OT_SENSOR) begin
      v = overtemp[2];
    end else if (sel == `CSM_MUX_CAN_CL) begin
      v = can_rail_enable ? can_rail_current_limit : 1'b1;
    end else if (sel == `CSM_MUX_TRIM_ERR) begin
      v = monitor_trim_fault;
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  csm_clk_mon #(
    .HALF_MAX (`CSM_LOSS_HALF_CYC)
  ) u_clk_mon (
    .clock      (clock),
    .rst        (rst),
    .enable     (clock_monitor_enable),
    .emulate    (clk_emulate),
    .osc_sample (osc_sample),
    .loss       (mon_loss)
  );

  // Emulated loss during the clock phase goes only to the test engine, the SAFE4 read and the diagnostic mux.
  assign real_loss = clock_monitor_enable && mon_loss &&
                     (phase != csm_pkg::ph_clk);
  assign running   = (phase != csm_pkg::ph_idle);
  assign test_done = (phase == csm_pkg::ph_done);
  assign ctrl_wr   = reg_write && (reg_addr == `CSM_REG_CTRL);
  assign mcu_may_test = (dev_state == csm_pkg::st_diag) ||
                        (dev_state == csm_pkg::st_active);
  assign start_auto = (dev_state == csm_pkg::st_reset) && !running;
  assign start_sw   = ctrl_wr && reg_wdata[`CSM_CTRL_START] &&
                      mcu_may_test && !running;
  assign check_sw   = ctrl_wr && reg_wdata[`CSM_CTRL_CLKCHK] &&
                      mcu_may_test && !running;
  assign starting   = start_auto || start_sw || check_sw;

  ////////////////////////////////////////////////////////////////////////////

  // Armed once power-on reset lets go; only the system reset disarms it.
  always_ff @(posedge clock) begin
    if (rst) begin
      clock_monitor_enable <= 1'b0;
    end else if (power_on_reset_n) begin
      clock_monitor_enable <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      dev_state <= csm_pkg::st_standby;
    end else if (real_loss) begin
      dev_state <= csm_pkg::st_standby;
    end else begin
      case (dev_state)
        csm_pkg::st_standby: begin
          if (power_on_reset_n && wake_request) begin
            dev_state <= csm_pkg::st_reset;
          end
        end
        csm_pkg::st_reset: begin
          dev_state <= csm_pkg::st_diag;
        end
        csm_pkg::st_diag: begin
          if (test_done && fail_acc) begin
            dev_state <= csm_pkg::st_safe;
          end else if (ctrl_wr && reg_wdata[`CSM_CTRL_GO_ACTIVE] &&
                       !running) begin
            dev_state <= csm_pkg::st_active;
          end
        end
        csm_pkg::st_active: begin
          dev_state <= csm_pkg::st_active;
        end
        csm_pkg::st_safe: begin
          dev_state <= csm_pkg::st_safe;
        end
        default: begin
          dev_state <= csm_pkg::st_standby;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst || real_loss) begin
      regulators_enable <= 1'b0;
      mcu_reset_n       <= 1'b0;
    end else begin
      regulators_enable <= (dev_state != csm_pkg::st_standby);
      mcu_reset_n       <= (dev_state == csm_pkg::st_diag) ||
                           (dev_state == csm_pkg::st_active) ||
                           (dev_state == csm_pkg::st_safe);
    end
  end

  // Dropped in the same edge that starts a test, so no gap.
  always_ff @(posedge clock) begin
    if (rst || real_loss) begin
      power_stage_enable_out <= 1'b0;
      supervision_enable     <= 1'b0;
    end else begin
      power_stage_enable_out <= (dev_state == csm_pkg::st_active) &&
                                !running && !starting;
      supervision_enable     <= (dev_state != csm_pkg::st_standby) &&
                                !running && !starting;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Phase sequencer; emulation drives only comparator test inputs and the
  // monitor's edge mask, never the rails or the oscillator.
  always_ff @(posedge clock) begin
    if (rst || real_loss) begin
      phase       <= csm_pkg::ph_idle;
      sub         <= 6'h00;
      halves      <= 4'h0;
      fail_acc    <= 1'b0;
      only_clk    <= 1'b0;
      cmp_emulate <= 1'b0;
      clk_emulate <= 1'b0;
      trim_addr   <= '0;
      crc         <= 8'h00;
    end else begin
      case (phase)
        csm_pkg::ph_idle: begin
          sub      <= 6'h00;
          halves   <= 4'h0;
          fail_acc <= 1'b0;
          if (start_auto || start_sw) begin
            phase    <= csm_pkg::ph_cmp;
            only_clk <= 1'b0;
          end else if (check_sw) begin
            phase    <= csm_pkg::ph_clk;
            only_clk <= 1'b1;
            clk_emulate <= 1'b1;
          end
        end
        csm_pkg::ph_cmp: begin
          if (sub == `CSM_CMP_HALF_CYC - 6'h01) begin
            sub <= 6'h00;
            if (cmp_test_resp != {RAILS{cmp_emulate}}) begin
              fail_acc <= 1'b1;
            end
            cmp_emulate <= !cmp_emulate;
            if (halves == `CSM_HALVES - 4'h1) begin
              halves      <= 4'h0;
              cmp_emulate <= 1'b0;
              // Open on an emulated loss so the last half is clean and the
              // monitor has settled before the loss mask lifts.
              clk_emulate <= 1'b1;
              phase       <= csm_pkg::ph_clk;
            end else begin
              halves <= halves + 4'h1;
            end
          end else begin
            sub <= sub + 6'h01;
          end
        end
        csm_pkg::ph_clk: begin
          if (sub == `CSM_EMU_HALF_CYC - 6'h01) begin
            sub <= 6'h00;
            if (mon_loss != clk_emulate) begin
              fail_acc <= 1'b1;
            end
            clk_emulate <= !clk_emulate;
            if (halves == `CSM_HALVES - 4'h1) begin
              halves      <= 4'h0;
              clk_emulate <= 1'b0;
              trim_addr   <= '0;
              crc         <= 8'h00;
              phase <= only_clk ? csm_pkg::ph_done : csm_pkg::ph_crc;
            end else begin
              halves <= halves + 4'h1;
            end
          end else begin
            sub <= sub + 6'h01;
          end
        end
        csm_pkg::ph_crc: begin
          // Last trim word holds the stored CRC of all words before it.
          if (trim_addr == TRIM_AW'(TRIM_WORDS - 1)) begin
            if (crc != trim_data) begin
              fail_acc <= 1'b1;
            end
            phase <= csm_pkg::ph_wait;
          end else begin
            crc       <= crc8_step(crc, trim_data);
            trim_addr <= trim_addr + TRIM_AW'(1);
          end
        end
        csm_pkg::ph_wait: begin
          if (cnt >= 16'(TEST_CYCLES - 2)) begin
            phase <= csm_pkg::ph_done;
          end
        end
        csm_pkg::ph_done: begin
          phase <= csm_pkg::ph_idle;
        end
        default: begin
          phase <= csm_pkg::ph_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst || !running) begin
      cnt <= 16'h0000;
    end else if (cnt != 16'hffff) begin
      cnt <= cnt + 16'h0001;
    end
  end

  // Written at the end of a run and cleared by a real loss, so a fail survives until a pass or a loss.
  always_ff @(posedge clock) begin
    if (rst || real_loss) begin
      analog_test_fail <= 1'b0;
    end else if (test_done) begin
      analog_test_fail <= fail_acc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Held during a test so emulated comparator toggles never show.
  always_ff @(posedge clock) begin
    if (rst) begin
      supply_flags <= '0;
    end else if (!running && !starting) begin
      supply_flags <= cmp_raw;
    end
  end

  // Reference taken at each passing run; any later difference is a flip.
  always_ff @(posedge clock) begin
    if (rst || real_loss) begin
      trim_ref           <= 8'h00;
      trim_ref_valid     <= 1'b0;
      monitor_trim_fault <= 1'b0;
    end else if (test_done && !fail_acc) begin
      trim_ref           <= mon_trim;
      trim_ref_valid     <= 1'b1;
      monitor_trim_fault <= 1'b0;
    end else if (trim_ref_valid && (mon_trim != trim_ref)) begin
      monitor_trim_fault <= 1'b1;
    end
  end

  // Set wins over a software clear in the same cycle.
  always_ff @(posedge clock) begin
    if (rst) begin
      clock_lost_flag <= 1'b0;
    end else if (real_loss) begin
      clock_lost_flag <= 1'b1;
    end else if (reg_write && (reg_addr == `CSM_REG_SAFE4) &&
                 reg_wdata[`CSM_SAFE4_CLKLOST]) begin
      clock_lost_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || real_loss) begin
      mux_sel         <= `CSM_MUXSEL_RST;
      can_rail_enable <= 1'(`CSM_SENSOR_RST >> `CSM_SENSOR_CANEN);
    end else if (reg_write && (reg_addr == `CSM_REG_MUXSEL)) begin
      mux_sel <= reg_wdata;
    end else if (reg_write && (reg_addr == `CSM_REG_SENSOR)) begin
      can_rail_enable <= reg_wdata[`CSM_SENSOR_CANEN];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      diag_out <= 1'b0;
    end else begin
      diag_out <= mux_pick(mux_sel);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (!reg_read) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == `CSM_REG_TSTAT) begin
      reg_rdata <= {6'h00, analog_test_fail, running};
    end else if (reg_addr == `CSM_REG_SAFE4) begin
      reg_rdata <= {7'h00, clock_lost_flag ||
                   ((phase == csm_pkg::ph_clk) && mon_loss)};
    end else if (reg_addr == `CSM_REG_SMSTAT) begin
      reg_rdata <= 8'(supply_flags);
    end else if (reg_addr == `CSM_REG_STATE) begin
      reg_rdata <= {5'h00, dev_state};
    end else if (reg_addr == `CSM_REG_MUXSEL) begin
      reg_rdata <= mux_sel;
    end else if (reg_addr == `CSM_REG_SENSOR) begin
      reg_rdata <= {7'h00, can_rail_enable};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  loss_to_standby_a: assert property (
    @(posedge clock) disable iff (rst)
    real_loss |=> (dev_state == csm_pkg::st_standby) && !mcu_reset_n &&
                  !regulators_enable)
    else $error("clock loss did not force standby");

  loss_flag_set_a: assert property (
    @(posedge clock) disable iff (rst)
    real_loss |=> clock_lost_flag [*2])
    else $error("clock lost flag not set");

  monitor_stays_on_a: assert property (
    @(posedge clock) disable iff (rst)
    clock_monitor_enable |=> clock_monitor_enable)
    else $error("clock monitor dropped");

  auto_start_a: assert property (
    @(posedge clock) disable iff (rst)
    (dev_state == csm_pkg::st_standby) ##1
    (dev_state == csm_pkg::st_reset) && !real_loss
    |=> (phase == csm_pkg::ph_cmp) && (dev_state == csm_pkg::st_diag))
    else $error("self-test not started on reset entry");

  run_gates_stage_a: assert property (
    @(posedge clock) disable iff (rst)
    running |-> !power_stage_enable_out && !supervision_enable)
    else $error("power stage enabled during self-test");

  diag_fail_safe_a: assert property (
    @(posedge clock) disable iff (rst)
    test_done && fail_acc && (dev_state == csm_pkg::st_diag) && !real_loss
    |=> (dev_state == csm_pkg::st_safe) && analog_test_fail ##1 mcu_reset_n)
    else $error("diag failure did not enter safe");

  active_fail_stay_a: assert property (
    @(posedge clock) disable iff (rst)
    test_done && fail_acc && (dev_state == csm_pkg::st_active) && !real_loss
    |=> (dev_state == csm_pkg::st_active) && analog_test_fail)
    else $error("active failure changed state");

  flags_frozen_a: assert property (
    @(posedge clock) disable iff (rst)
    running && $past(running) |-> $stable(supply_flags))
    else $error("supply flags moved during self-test");

  can_limit_high_a: assert property (
    @(posedge clock) disable iff (rst)
    ($past(mux_sel) == `CSM_MUX_CAN_CL) && !$past(can_rail_enable)
    |-> diag_out)
    else $error("can rail limit not high while disabled");

  run_bit_read_a: assert property (
    @(posedge clock) disable iff (rst)
    reg_read && (reg_addr == `CSM_REG_TSTAT)
    |=> reg_rdata[`CSM_TSTAT_RUN] == $past(running))
    else $error("running bit wrong");

endmodule
`default_nettype wire

// ===== csm_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHECK_EQ(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); \
  end \
end

module csm_top_tb_top;
  localparam int unsigned TEST_CYCLES = 500;
  typedef struct packed {
    logic [7:0] sel;
    logic [2:0] ot;
    logic       cl;
    logic       en;
    logic       exp;
  } csm_row_t;
  logic                clock, rst, power_on_reset_n, wake_request;
  logic                osc_sample, can_rail_current_limit, trim_bad;
  logic                reg_write, reg_read, regulators_enable;
  logic                mcu_reset_n, power_stage_enable_out;
  logic                supervision_enable, clock_monitor_enable;
  logic                cmp_emulate, monitor_trim_fault, diag_out;
  logic [7:0]          cmp_raw, cmp_test_resp, trim_data, mon_trim;
  logic [7:0]          reg_wdata, reg_rdata, supply_flags, rd;
  logic [3:0]          reg_addr, trim_addr;
  logic [2:0]          overtemp;
  logic [1:0]          osc_mode;
  csm_pkg::csm_state_t dev_state;
  int                  bad_count, total_checks, cyc;
  csm_row_t            rows [9] = '{
    '{8'h6c, 3'h1, 1'b0, 1'b1, 1'b1}, '{8'h6d, 3'h2, 1'b0, 1'b1, 1'b1},
    '{8'h6e, 3'h4, 1'b0, 1'b1, 1'b1}, '{8'h6d, 3'h1, 1'b0, 1'b1, 1'b0},
    '{8'h6f, 3'h0, 1'b0, 1'b0, 1'b1}, '{8'h6f, 3'h0, 1'b0, 1'b1, 1'b0},
    '{8'h6f, 3'h0, 1'b1, 1'b1, 1'b1}, '{8'h89, 3'h0, 1'b0, 1'b1, 1'b0},
    '{8'h30, 3'h7, 1'b1, 1'b1, 1'b0}};

  csm_top #(.TEST_CYCLES(TEST_CYCLES)) i_csm_top (.clock(clock), .rst(rst),
    .power_on_reset_n(power_on_reset_n), .wake_request(wake_request),
    .osc_sample(osc_sample), .cmp_raw(cmp_raw),
    .cmp_test_resp(cmp_test_resp), .trim_data(trim_data),
    .mon_trim(mon_trim), .overtemp(overtemp),
    .can_rail_current_limit(can_rail_current_limit), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .dev_state(dev_state),
    .regulators_enable(regulators_enable), .mcu_reset_n(mcu_reset_n),
    .power_stage_enable_out(power_stage_enable_out),
    .supervision_enable(supervision_enable),
    .clock_monitor_enable(clock_monitor_enable),
    .cmp_emulate(cmp_emulate), .trim_addr(trim_addr),
    .supply_flags(supply_flags), .monitor_trim_fault(monitor_trim_fault),
    .diag_out(diag_out));
  csm_analog_model i_csm_analog_model (.clock(clock), .osc_mode(osc_mode),
    .trim_bad(trim_bad), .cmp_emulate(cmp_emulate), .trim_addr(trim_addr),
    .osc_sample(osc_sample), .cmp_test_resp(cmp_test_resp),
    .trim_data(trim_data));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Polling granularity is two cycles, hence the slack on the length
  task automatic wait_test(input int len);
    int t0;
    rd = 8'h00;
    for (int i = 0; i < 40 && rd[0] !== 1'b1; i++) reg_rd(4'h1, rd);
    `CHECK_EQ(rd[0], 1'b1)
    t0 = cyc;
    for (int i = 0; i < 2000 && rd[0] !== 1'b0; i++) reg_rd(4'h1, rd);
    `CHECK_EQ(rd[0], 1'b0)
    `CHECK_EQ((cyc - t0 + 12 > len) && (cyc - t0 < len + 12), 1'b1)
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #(20 * 20000);
    bad_count++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////
  initial begin
    {rst, power_on_reset_n, wake_request, trim_bad} = 4'h8;
    {reg_write, reg_read, can_rail_current_limit} = 3'h0;
    {cmp_raw, mon_trim, reg_wdata, reg_addr, overtemp} = 31'h0;
    {osc_mode, bad_count, total_checks} = '0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
    `CHECK_EQ(clock_monitor_enable, 1'b0)
    `CHECK_EQ({regulators_enable, power_stage_enable_out}, 2'h0)
    power_on_reset_n <= 1'b1;
    wake_request <= 1'b1;
    wait_test(TEST_CYCLES);
    `CHECK_EQ(clock_monitor_enable, 1'b1)
    `CHECK_EQ(dev_state, csm_pkg::st_diag)
    foreach (rows[k]) begin
      overtemp <= rows[k].ot;
      can_rail_current_limit <= rows[k].cl;
      reg_wr(4'h6, {7'h00, rows[k].en});
      reg_wr(4'h5, rows[k].sel);
      reg_rd(4'h5, rd);
      `CHECK_EQ(rd, rows[k].sel)
      `CHECK_EQ(diag_out, rows[k].exp)
    end
    cmp_raw <= 8'h5a;
    mon_trim <= 8'h01;
    reg_rd(4'h3, rd);
    `CHECK_EQ(rd, 8'h5a)
    `CHECK_EQ(monitor_trim_fault, 1'b1)
    reg_wr(4'h0, 8'h04);
    repeat (2) @(posedge clock);
    #1;
    `CHECK_EQ({dev_state, power_stage_enable_out}, {csm_pkg::st_active, 1'b1})
    trim_bad <= 1'b1;
    reg_wr(4'h0, 8'h01);
    cmp_raw <= 8'h0f;
    repeat (3) @(posedge clock);
    #1;
    `CHECK_EQ({power_stage_enable_out, supervision_enable}, 2'h0)
    `CHECK_EQ(supply_flags, 8'h5a)
    wait_test(TEST_CYCLES);
    `CHECK_EQ(rd[1], 1'b1)
    `CHECK_EQ({dev_state, supply_flags}, {csm_pkg::st_active, 8'h0f})
    trim_bad <= 1'b0;
    reg_wr(4'h0, 8'h02);
    // Emulated loss needs about ten cycles to reach the status bit
    repeat (16) @(posedge clock);
    reg_rd(4'h2, rd);
    `CHECK_EQ(rd[0], 1'b1)
    `CHECK_EQ(dev_state, csm_pkg::st_active)
    // Polling starts twenty cycles into the recheck
    wait_test(257 - 20);
    reg_wr(4'h2, 8'h01);
    reg_rd(4'h2, rd);
    `CHECK_EQ(rd[0], 1'b0)
    // Stuck high, stuck low, then slow; the last restart fails its test
    for (int m = 1; m < 4; m++) begin
      osc_mode <= 2'(m);
      for (int i = 0; i < 60 && dev_state !== csm_pkg::st_standby; i++)
        @(posedge clock);
      #1;
      `CHECK_EQ({dev_state, regulators_enable, mcu_reset_n}, 5'h0)
      reg_rd(4'h2, rd);
      `CHECK_EQ(rd[0], 1'b1)
      trim_bad <= (m == 3);
      osc_mode <= 2'h0;
      wait_test(TEST_CYCLES);
      `CHECK_EQ(dev_state, (m == 3) ? csm_pkg::st_safe : csm_pkg::st_diag)
      reg_wr(4'h2, 8'h01);
    end
    `CHECK_EQ({rd[1], mcu_reset_n, clock_monitor_enable}, 3'h7)
    print_verdict();
  end
endmodule

`default_nettype wire
